// file: adcrc_top.sv
// Purpose: post-conversion accumulate, filter, error and threshold unit
// Assumes: clock_i is the converter clock, either system-derived or rc
// Notes: results enter through an 8-word fifo; control bits are plain ports
//
// Summary of operation
// R1 - accumulator is a 16-bit register visible to software
// R2 - every accumulating mode adds the result on each trigger event
// R3 - overflow flag sets when a sum passes 65535
// R4 - sample count increments for every sample accumulated, holding at 255 once it gets there
// R5 - clear request zeroes accumulator, overflow flag and sample count
// R6 - clear bit returns low by itself when clearing finishes
// R7 - on the rc clock a clear takes five cycles
// R8 - accumulate and average modes copy shifted accumulator to filtered value
// R9 - accumulator stays right-justified whatever the result format
// R10 - basic mode: no accumulation, error comparison still runs
// R11 - accumulate mode: add, count, compare after every sample
// R12 - average mode: compare only once count reaches repeat target
// R13 - average mode: next trigger after target clears accumulator first
// R14 - burst mode retriggers until count reaches target, even without continuous
// R15 - burst mode clears accumulator when a burst is started
// R16 - low-pass mode filters samples, compares once count reaches target
// R17 - low-pass update: sample plus accumulator minus shifted accumulator
// R18 - shift field one to six sets low-pass cutoff
// R19 - results latched at computation end for the error calculation
// R20 - error select 111 loads filtered value in both sample modes
// R21 - error select picks among result, previous, filtered and setpoint differences
// R22 - with double sampling error is computed only after second sample
// R23 - error compared to thresholds, above and below flags updated
// R24 - test select chooses one of eight threshold conditions
// R25 - conditions encoded 000 never through 111 always
// R26 - threshold comparisons are signed
// R27 - met condition at computation end sets threshold interrupt flag
// R28 - accumulator overflow also raises threshold interrupt flag
`timescale 1ns/1ps
module adcrc_top
  import adcrc_pkg::*;
#(
  parameter int FIFO_D = FIFO_DEPTH
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire adcrc_cfg_s cfg_i,
  input wire logic conversion_go_i,
  input wire logic ext_trigger_i,
  input wire logic accumulator_clear_i,
  input wire logic threshold_flag_clear_i,
  input wire logic [CNT_W-1:0] repeat_target_i,
  input wire logic [ACC_W-1:0] setpoint_i,
  input wire logic [ACC_W-1:0] upper_threshold_i,
  input wire logic [ACC_W-1:0] lower_threshold_i,
  input wire logic conv_valid_i,
  input wire logic [ACC_W-1:0] conv_data_i,
  output logic conv_ready_o,
  output logic conv_start_o,
  output logic [ACC_W-1:0] accumulator_value_o,
  output logic accumulator_overflow_o,
  output logic [CNT_W-1:0] sample_count_o,
  output logic accumulator_clear_o,
  output logic [ACC_W-1:0] filtered_value_o,
  output logic [ACC_W-1:0] error_value_o,
  output logic [ACC_W-1:0] conversion_result_o,
  output logic [ACC_W-1:0] previous_result_o,
  output logic above_upper_flag_o,
  output logic below_lower_flag_o,
  output logic threshold_irq_flag_o
);

  logic ext_meta_r;
  logic ext_sync_r;
  logic ext_prev_r;
  logic ext_edge;
  logic trig_go;
  logic trig_any;
  logic retrig_r;
  logic burst_act_r;
  logic [2:0] clr_cnt_r;
  logic fifo_valid;
  logic [ACC_W-1:0] fifo_data;
  logic fifo_ready;
  logic pop;
  logic do_acc;
  logic accumulating;
  logic trig_clear;
  adcrc_pair_e pair_r;
  logic [ACC_W-1:0] first_r;
  logic [ACC_W-1:0] sample;
  logic [ACC_W:0] sum_nxt;
  logic [CNT_W-1:0] cnt_nxt;
  logic calc_r;
  logic test_en;
  logic [ACC_W-1:0] err_nxt;
  logic [ACC_W-1:0] cvd;
  logic signed [ACC_W-1:0] err_s;
  logic signed [ACC_W-1:0] up_s;
  logic signed [ACC_W-1:0] lo_s;
  logic cond;
  logic ovf_set;

  // external trigger crosses in through two flops
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      ext_meta_r <= ext_trigger_i;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
    end
  end

  assign ext_edge = ext_sync_r & ~ext_prev_r;
  assign trig_go = conversion_go_i | ext_edge; // [R2]
  assign trig_any = trig_go | retrig_r;

  adcrc_fifo #(
    .W(ACC_W),
    .D(FIFO_D)
  ) u_fifo (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(conv_valid_i),
    .in_data_i(conv_data_i),
    .in_ready_o(conv_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(fifo_ready)
  );

  // draining stalls while clearing, on a trigger and while error is computed
  assign fifo_ready = ~accumulator_clear_o & ~trig_any & ~calc_r;
  assign pop = fifo_valid & fifo_ready;
  assign do_acc = pop & (~cfg_i.dsen | pair_r == SMP_SECOND); // [R22]
  assign accumulating = cfg_i.mode != MD_BASIC && cfg_i.mode <= MD_LPF; // [R10]
  assign trig_clear = trig_any & ((cfg_i.mode == MD_BURST & trig_go) // [R15]
    | (cfg_i.mode == MD_AVG & sample_count_o >= repeat_target_i)); // [R13]

  // result words are right-justified, format never reaches here
  assign sample = cfg_i.dsen ? fifo_data - first_r : fifo_data; // [R9]

  always_comb begin
    sum_nxt = {1'b0, accumulator_value_o} + {1'b0, sample}; // [R2]
    if (cfg_i.mode == MD_LPF) begin
      sum_nxt = sum_nxt - {1'b0, accumulator_value_o >> cfg_i.shift}; // [R17] [R18]
    end
  end

  assign cnt_nxt = (sample_count_o == CNT_MAX) ? sample_count_o : sample_count_o + CNT_W'(1); // [R4]
  assign ovf_set = do_acc & accumulating & sum_nxt[ACC_W]; // [R3]

  // double-sample pairing
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pair_r <= SMP_FIRST;
      first_r <= ACC_RST;
    end else if (~cfg_i.dsen) begin
      pair_r <= SMP_FIRST;
    end else if (pop) begin
      unique case (pair_r)
        SMP_FIRST: begin
          pair_r <= SMP_SECOND;
          first_r <= fifo_data;
        end
        SMP_SECOND: pair_r <= SMP_FIRST;
      endcase
    end
  end

  // clear request and its busy bit
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      accumulator_clear_o <= 1'b0;
      clr_cnt_r <= 3'h0;
    end else if (accumulator_clear_i) begin
      accumulator_clear_o <= 1'b1;
      clr_cnt_r <= cfg_i.rc ? CLR_RC_CYCLES : CLR_SYS_CYCLES; // [R7]
    end else if (accumulator_clear_o) begin
      clr_cnt_r <= clr_cnt_r - 3'h1;
      if (clr_cnt_r == 3'h1) begin
        accumulator_clear_o <= 1'b0; // [R6]
      end
    end
  end

  // accumulator, count and overflow
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      accumulator_value_o <= ACC_RST;
      sample_count_o <= CNT_RST;
      accumulator_overflow_o <= 1'b0;
    end else if (accumulator_clear_o | trig_clear) begin
      accumulator_value_o <= ACC_RST; // [R5] [R13] [R15]
      sample_count_o <= CNT_RST;
      accumulator_overflow_o <= 1'b0;
    end else if (do_acc & accumulating) begin
      accumulator_value_o <= sum_nxt[ACC_W-1:0]; // [R1] [R2] [R11]
      sample_count_o <= cnt_nxt; // [R4]
      if (ovf_set) begin
        accumulator_overflow_o <= 1'b1; // [R3]
      end
    end
  end

  // filtered value and latched results
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      filtered_value_o <= ACC_RST;
      conversion_result_o <= ACC_RST;
      previous_result_o <= ACC_RST;
    end else if (do_acc) begin
      conversion_result_o <= fifo_data; // [R19]
      previous_result_o <= cfg_i.dsen ? first_r : conversion_result_o;
      if (accumulating) begin
        filtered_value_o <= sum_nxt[ACC_W-1:0] >> cfg_i.shift; // [R8] [R16]
      end
    end
  end

  // retrigger and burst tracking
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      burst_act_r <= 1'b0;
      retrig_r <= 1'b0;
      conv_start_o <= 1'b0;
    end else begin
      conv_start_o <= trig_any;
      if (trig_go & cfg_i.mode == MD_BURST) begin
        burst_act_r <= 1'b1;
      end else if (do_acc & cnt_nxt >= repeat_target_i) begin
        burst_act_r <= 1'b0;
      end
      retrig_r <= pop & (cfg_i.cont | (cfg_i.mode == MD_BURST & burst_act_r // [R14]
        & ~(do_acc & cnt_nxt >= repeat_target_i)));
    end
  end

  // error calculation one cycle after the computation
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      calc_r <= 1'b0;
    end else begin
      calc_r <= do_acc; // [R22]
    end
  end

  assign cvd = cfg_i.dsen ? conversion_result_o - previous_result_o : conversion_result_o;

  always_comb begin
    unique case (cfg_i.calc) // [R21]
      CALC_RES_PREV: err_nxt = conversion_result_o - previous_result_o;
      CALC_RES_STPT: err_nxt = cvd - setpoint_i;
      CALC_RES_FLT: err_nxt = cvd - filtered_value_o;
      CALC_RSVD: err_nxt = ACC_RST;
      CALC_PREV_FLT: err_nxt = previous_result_o - filtered_value_o;
      CALC_FLT_STPT: err_nxt = filtered_value_o - setpoint_i;
      CALC_RES: err_nxt = conversion_result_o;
      CALC_FLT: err_nxt = filtered_value_o; // [R20]
    endcase
  end

  assign err_s = $signed(err_nxt); // [R26]
  assign up_s = $signed(upper_threshold_i);
  assign lo_s = $signed(lower_threshold_i);
  assign test_en = (cfg_i.mode == MD_BASIC | cfg_i.mode == MD_ACCUM) // [R10] [R11]
    | sample_count_o >= repeat_target_i; // [R12] [R16]

  always_comb begin
    unique case (cfg_i.tmd) // [R24] [R25]
      TM_NEVER: cond = 1'b0;
      TM_BELOW_LO: cond = err_s < lo_s;
      TM_GE_LO: cond = err_s >= lo_s;
      TM_INSIDE: cond = err_s >= lo_s && err_s <= up_s;
      TM_OUTSIDE: cond = err_s < lo_s || err_s > up_s;
      TM_LE_UP: cond = err_s <= up_s;
      TM_ABOVE_UP: cond = err_s > up_s;
      TM_ALWAYS: cond = 1'b1;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      error_value_o <= ACC_RST;
      above_upper_flag_o <= 1'b0;
      below_lower_flag_o <= 1'b0;
    end else if (calc_r) begin
      error_value_o <= err_nxt;
      above_upper_flag_o <= err_s > up_s; // [R23] [R26]
      below_lower_flag_o <= err_s < lo_s; // [R23]
    end
  end

  // sticky flag: a set in the clear cycle wins
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      threshold_irq_flag_o <= 1'b0;
    end else if ((calc_r & test_en & cond) | ovf_set) begin
      threshold_irq_flag_o <= 1'b1; // [R27] [R28]
    end else if (threshold_flag_clear_i) begin
      threshold_irq_flag_o <= 1'b0;
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_clr_rc;
    accumulator_clear_i & cfg_i.rc;
  endsequence

  sequence s_clr_sys;
    (accumulator_clear_i & ~cfg_i.rc) ##1 ~accumulator_clear_i;
  endsequence

  AST_ACC_ADD: assert property ( // [R2]
    do_acc & cfg_i.mode == MD_ACCUM & ~accumulator_clear_o
    |=> accumulator_value_o == $past(accumulator_value_o) + $past(sample))
    else $error("accumulator did not add sample");
  AST_OVF_SET: assert property ( // [R3]
    ovf_set & ~accumulator_clear_o & ~trig_clear |=> accumulator_overflow_o)
    else $error("overflow flag not set");
  AST_CNT_INC: assert property ( // [R4]
    do_acc & accumulating & ~accumulator_clear_o & ~trig_clear & sample_count_o != CNT_MAX
    |=> sample_count_o == $past(sample_count_o) + 8'h01)
    else $error("sample count not incremented");
  AST_CLR_VALUES: assert property ( // [R5]
    accumulator_clear_i |=> ##1 accumulator_value_o == ACC_RST & sample_count_o == CNT_RST
    & ~accumulator_overflow_o)
    else $error("clear left state behind");
  AST_CLR_END: assert property ( // [R6]
    s_clr_sys |=> ~accumulator_clear_o)
    else $error("clear bit not released");
  AST_CLR_RC: assert property ( // [R7]
    s_clr_rc ##1 ~accumulator_clear_i[*5] |-> accumulator_clear_o ##1 ~accumulator_clear_o)
    else $error("rc clear length wrong");
  AST_FILT: assert property ( // [R8]
    do_acc & accumulating & ~accumulator_clear_o & ~trig_clear
    |=> filtered_value_o == accumulator_value_o >> $past(cfg_i.shift))
    else $error("filtered value mismatch");
  AST_BASIC: assert property ( // [R10]
    do_acc & cfg_i.mode == MD_BASIC & ~accumulator_clear_o |=> $stable(accumulator_value_o))
    else $error("basic mode accumulated");
  AST_ERR_FLT: assert property ( // [R20]
    calc_r & cfg_i.calc == CALC_FLT |=> error_value_o == $past(filtered_value_o))
    else $error("error not filtered value");
  AST_PAIR: assert property ( // [R22]
    pop & cfg_i.dsen & pair_r == SMP_FIRST |=> ##1 $stable(error_value_o))
    else $error("error computed on first sample");
  AST_SIGNED: assert property ( // [R26]
    calc_r |=> above_upper_flag_o == ($signed(error_value_o) > $signed($past(upper_threshold_i))))
    else $error("upper compare not signed");
  AST_IRQ: assert property ( // [R27]
    calc_r & test_en & cond |=> threshold_irq_flag_o)
    else $error("threshold flag not set");
  AST_OVF_IRQ: assert property ( // [R28]
    $rose(accumulator_overflow_o) |-> threshold_irq_flag_o)
    else $error("overflow without threshold flag");

endmodule

// file: adcrc_pkg.sv
// Purpose: shared constants and types for the adc result computation unit
// Assumes: one clock, synchronous active-high reset
// Notes: mode, error-select and threshold-select codes are 3-bit fields
package adcrc_pkg;

  localparam int ACC_W = 16;
  localparam int CNT_W = 8;
  localparam int FIFO_DEPTH = 8;

  localparam logic [ACC_W-1:0] ACC_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;

  // clear duration in converter clock cycles
  localparam logic [2:0] CLR_RC_CYCLES = 3'h5;
  localparam logic [2:0] CLR_SYS_CYCLES = 3'h1;

  // computation select codes
  localparam logic [2:0] MD_BASIC = 3'h0;
  localparam logic [2:0] MD_ACCUM = 3'h1;
  localparam logic [2:0] MD_AVG = 3'h2;
  localparam logic [2:0] MD_BURST = 3'h3;
  localparam logic [2:0] MD_LPF = 3'h4;

  // error calc select codes
  localparam logic [2:0] CALC_RES_PREV = 3'h0;
  localparam logic [2:0] CALC_RES_STPT = 3'h1;
  localparam logic [2:0] CALC_RES_FLT = 3'h2;
  localparam logic [2:0] CALC_RSVD = 3'h3;
  localparam logic [2:0] CALC_PREV_FLT = 3'h4;
  localparam logic [2:0] CALC_FLT_STPT = 3'h5;
  localparam logic [2:0] CALC_RES = 3'h6;
  localparam logic [2:0] CALC_FLT = 3'h7;

  // threshold test select codes
  localparam logic [2:0] TM_NEVER = 3'h0;
  localparam logic [2:0] TM_BELOW_LO = 3'h1;
  localparam logic [2:0] TM_GE_LO = 3'h2;
  localparam logic [2:0] TM_INSIDE = 3'h3;
  localparam logic [2:0] TM_OUTSIDE = 3'h4;
  localparam logic [2:0] TM_LE_UP = 3'h5;
  localparam logic [2:0] TM_ABOVE_UP = 3'h6;
  localparam logic [2:0] TM_ALWAYS = 3'h7;

  typedef struct packed {
    logic [2:0] mode;
    logic [2:0] shift;
    logic [2:0] calc;
    logic [2:0] tmd;
    logic dsen;
    logic cont;
    logic rc;
  } adcrc_cfg_s;

  typedef enum logic {SMP_FIRST, SMP_SECOND} adcrc_pair_e;

endpackage

// file: adcrc_fifo.sv
// Purpose: small flop-based fifo for conversion results
// Assumes: same clock on both sides
// Notes: in_ready_o is a flop, so it lags a pop by one cycle
`timescale 1ns/1ps
module adcrc_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic push;
  logic pop;

  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_valid_o = count_r != '0;
  assign out_data_o = mem_r[rd_ptr_r];

  always_comb begin
    count_nxt = count_r;
    if (push & ~pop) begin
      count_nxt = count_r + CW'(1);
    end else if (pop & ~push) begin
      count_nxt = count_r - CW'(1);
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      count_r <= '0;
      in_ready_o <= 1'b0;
    end else begin
      count_r <= count_nxt;
      in_ready_o <= count_nxt < CW'(D);
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(D - 1)) ? '0 : wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(D - 1)) ? '0 : rd_ptr_r + AW'(1);
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

endmodule

// file: adcrc_core_model.sv
// Purpose: behavioural conversion core answering conversion requests
// Assumes: one result per request, valid held until ready is seen
// Notes: released data line shows the inverse of the last word
`timescale 1ns/1ps
module adcrc_core_model
  import adcrc_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic conv_start_i,
  input wire logic conv_ready_i,
  input wire logic slow_i,
  input wire logic [ACC_W-1:0] sample_i,
  output logic conv_valid_o,
  output logic [ACC_W-1:0] conv_data_o,
  output logic [15:0] sent_o
);
  logic [7:0] pend_r;
  logic [1:0] wait_r;
  logic take;
  assign take = !conv_valid_o && (pend_r != 8'h00) && (wait_r == 2'h0);
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pend_r <= 8'h00;
      wait_r <= 2'h0;
      conv_valid_o <= 1'h0;
      conv_data_o <= 16'h0000;
      sent_o <= 16'h0000;
    end else begin
      pend_r <= pend_r + {7'h00, conv_start_i} - {7'h00, take};
      if (conv_valid_o && conv_ready_i) begin
        conv_valid_o <= 1'h0;
        conv_data_o <= ~conv_data_o;
        sent_o <= sent_o + 16'h0001;
        wait_r <= slow_i ? 2'h3 : 2'h0;
      end else if (take) begin
        conv_valid_o <= 1'h1;
        conv_data_o <= sample_i;
      end else if (!conv_valid_o && wait_r != 2'h0) begin
        wait_r <= wait_r - 2'h1;
      end
    end
  end
endmodule

// file: test_adc_result_computation_unit.sv
// Purpose: self-checking bench for the result computation unit
// Assumes: core model answers every conversion request
// Notes: table rows cover error selects and threshold tests
`timescale 1ns/1ps
module test_adc_result_computation_unit
  import adcrc_pkg::*;
;
  typedef struct packed {
    logic [2:0] calc;
    logic [2:0] tmd;
    logic [15:0] smp;
    logic [15:0] err;
    logic irq;
    logic above;
    logic below;
  } adcrc_row_s;
  adcrc_row_s rows[10] = '{
    '{3'h6, 3'h7, 16'h0040, 16'h0040, 1'h1, 1'h0, 1'h0},
    '{3'h1, 3'h1, 16'h0020, 16'hffa0, 1'h1, 1'h0, 1'h1},
    '{3'h2, 3'h2, 16'h0100, 16'h0080, 1'h1, 1'h0, 1'h0},
    '{3'h5, 3'h3, 16'h0300, 16'h0100, 1'h1, 1'h0, 1'h0},
    '{3'h0, 3'h4, 16'h0010, 16'hfd10, 1'h1, 1'h0, 1'h1},
    '{3'h4, 3'h5, 16'h0400, 16'hfe10, 1'h1, 1'h0, 1'h1},
    '{3'h7, 3'h6, 16'h0202, 16'h0101, 1'h1, 1'h1, 1'h0},
    '{3'h3, 3'h0, 16'h0050, 16'h0000, 1'h0, 1'h0, 1'h1},
    '{3'h6, 3'h6, 16'h0050, 16'h0050, 1'h0, 1'h0, 1'h0},
    '{3'h6, 3'h1, 16'h0050, 16'h0050, 1'h0, 1'h0, 1'h0}};
  logic clock_i, sys_rst_i, go, ext, aclr, tclr, slow, cvalid, cready, cstart;
  logic ovf, busy, above, below, irq;
  adcrc_cfg_s cfg;
  logic [7:0] rpt, cnt;
  logic [15:0] stpt, uth, lth, cdata, sample, sent, acc, flt, err, res, prev, s0;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  int nb;
  adcrc_top dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .cfg_i(cfg), .conversion_go_i(go),
    .ext_trigger_i(ext), .accumulator_clear_i(aclr), .threshold_flag_clear_i(tclr), .repeat_target_i(rpt),
    .setpoint_i(stpt), .upper_threshold_i(uth), .lower_threshold_i(lth), .conv_valid_i(cvalid),
    .conv_data_i(cdata), .conv_ready_o(cready), .conv_start_o(cstart), .accumulator_value_o(acc),
    .accumulator_overflow_o(ovf), .sample_count_o(cnt), .accumulator_clear_o(busy), .filtered_value_o(flt),
    .error_value_o(err), .conversion_result_o(res), .previous_result_o(prev), .above_upper_flag_o(above),
    .below_lower_flag_o(below), .threshold_irq_flag_o(irq));
  adcrc_core_model core (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .conv_start_i(cstart),
    .conv_ready_i(cready), .slow_i(slow), .sample_i(sample), .conv_valid_o(cvalid), .conv_data_o(cdata),
    .sent_o(sent));
  initial begin
    clock_i = 1'h0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic setcfg(input logic [2:0] md, sh, calc, tmd, input logic ds, rc);
    @(posedge clock_i);
    cfg <= '{md, sh, calc, tmd, ds, 1'h0, rc};
  endtask
  // one trigger, then wait for n words taken by the unit
  task automatic conv(input logic [15:0] s, input logic [15:0] n, input logic use_ext);
    logic [15:0] n0;
    int k;
    n0 = sent;
    k = 0;
    @(posedge clock_i);
    sample <= s;
    go <= !use_ext;
    ext <= use_ext;
    @(posedge clock_i);
    go <= 1'h0;
    while (sent !== n0 + n && k < 200) begin
      @(posedge clock_i);
      k++;
    end
    cmp("words_taken", n0 + n, sent);
    repeat (6) @(posedge clock_i);
    ext <= 1'h0;
  endtask
  task automatic clr(output int busy_n);
    @(posedge clock_i);
    aclr <= 1'h1;
    tclr <= 1'h1;
    @(posedge clock_i);
    aclr <= 1'h0;
    tclr <= 1'h0;
    busy_n = 0;
    repeat (10) begin
      @(posedge clock_i);
      if (busy === 1'h1) busy_n++;
    end
  endtask
  initial begin
    sys_rst_i = 1'h1;
    cfg = '0;
    {go, ext, aclr, tclr, slow} = 5'h00;
    rpt = 8'h02;
    stpt = 16'h0080;
    uth = 16'h0100;
    lth = 16'h0010;
    sample = 16'h0000;
    repeat (16) @(posedge clock_i);
    sys_rst_i <= 1'h0;
    repeat (2) @(posedge clock_i);
    cmp("accumulator", 16'h0000, acc);
    cmp("irq_flag", 16'h0000, irq);
    cmp("conv_ready", 16'h0001, cready);
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      setcfg(MD_ACCUM, 3'h1, rows[i].calc, rows[i].tmd, 1'h0, 1'h0);
      clr(nb);
      cmp("clear_busy", 16'h0001, nb[15:0]);
      conv(rows[i].smp, 16'h0001, 1'h0);
      cmp("accumulator", rows[i].smp, acc);
      cmp("sample_count", 16'h0001, {8'h00, cnt});
      cmp("filtered", rows[i].smp >> 1, flt);
      cmp("error", rows[i].err, err);
      cmp("above_upper", rows[i].above, above);
      cmp("below_lower", rows[i].below, below);
      cmp("irq_flag", rows[i].irq, irq);
    end
    $display("test table done");
    setcfg(MD_ACCUM, 3'h0, CALC_RES, TM_NEVER, 1'h0, 1'h0);
    clr(nb);
    conv(16'hff00, 16'h0001, 1'h0);
    conv(16'hff00, 16'h0001, 1'h1);
    cmp("overflow", 16'h0001, ovf);
    cmp("irq_flag", 16'h0001, irq);
    cmp("accumulator", 16'hfe00, acc);
    cmp("sample_count", 16'h0002, {8'h00, cnt});
    setcfg(MD_ACCUM, 3'h0, CALC_RES, TM_NEVER, 1'h0, 1'h1);
    clr(nb);
    cmp("clear_busy", 16'h0005, nb[15:0]);
    cmp("accumulator", 16'h0000, acc);
    cmp("overflow", 16'h0000, ovf);
    cmp("sample_count", 16'h0000, {8'h00, cnt});
    cmp("clear_bit", 16'h0000, busy);
    $display("test overflow and clear done");
    setcfg(MD_BASIC, 3'h0, CALC_RES, TM_ALWAYS, 1'h0, 1'h0);
    clr(nb);
    conv(16'h0040, 16'h0001, 1'h0);
    cmp("accumulator", 16'h0000, acc);
    cmp("sample_count", 16'h0000, {8'h00, cnt});
    cmp("error", 16'h0040, err);
    cmp("irq_flag", 16'h0001, irq);
    setcfg(MD_AVG, 3'h0, CALC_RES, TM_ALWAYS, 1'h0, 1'h0);
    clr(nb);
    conv(16'h0010, 16'h0001, 1'h0);
    cmp("irq_flag", 16'h0000, irq);
    conv(16'h0020, 16'h0001, 1'h0);
    cmp("irq_flag", 16'h0001, irq);
    cmp("accumulator", 16'h0030, acc);
    conv(16'h0005, 16'h0001, 1'h0);
    cmp("accumulator", 16'h0005, acc);
    cmp("sample_count", 16'h0001, {8'h00, cnt});
    $display("test basic and average done");
    rpt <= 8'h03;
    slow <= 1'h1;
    setcfg(MD_BURST, 3'h0, CALC_FLT, TM_ALWAYS, 1'h0, 1'h0);
    clr(nb);
    conv(16'h0007, 16'h0003, 1'h0);
    cmp("sample_count", 16'h0003, {8'h00, cnt});
    cmp("accumulator", 16'h0015, acc);
    cmp("irq_flag", 16'h0001, irq);
    s0 = sent;
    repeat (20) @(posedge clock_i);
    cmp("words_taken", s0, sent);
    conv(16'h0002, 16'h0003, 1'h0);
    cmp("accumulator", 16'h0006, acc);
    cmp("sample_count", 16'h0003, {8'h00, cnt});
    $display("test burst done");
    rpt <= 8'h02;
    slow <= 1'h0;
    setcfg(MD_LPF, 3'h2, CALC_FLT, TM_ALWAYS, 1'h0, 1'h0);
    clr(nb);
    conv(16'h0064, 16'h0001, 1'h0);
    cmp("irq_flag", 16'h0000, irq);
    cmp("accumulator", 16'h0064, acc);
    conv(16'h0064, 16'h0001, 1'h0);
    cmp("accumulator", 16'h00af, acc);
    cmp("filtered", 16'h002b, flt);
    cmp("irq_flag", 16'h0001, irq);
    setcfg(MD_ACCUM, 3'h0, CALC_FLT, TM_ALWAYS, 1'h1, 1'h0);
    clr(nb);
    conv(16'h0030, 16'h0001, 1'h0);
    cmp("irq_flag", 16'h0000, irq);
    conv(16'h0050, 16'h0001, 1'h0);
    cmp("irq_flag", 16'h0001, irq);
    cmp("result", 16'h0050, res);
    cmp("previous", 16'h0030, prev);
    cmp("error", 16'h0020, err);
    $display("test filter and double sample done");
    sys_rst_i <= 1'h1;
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'h0;
    repeat (2) @(posedge clock_i);
    cmp("accumulator", 16'h0000, acc);
    cmp("error", 16'h0000, err);
    cmp("irq_flag", 16'h0000, irq);
    cmp("conv_ready", 16'h0001, cready);
    $display("test mid-run reset done");
    setcfg(MD_ACCUM, 3'h0, CALC_RES, TM_NEVER, 1'h0, 1'h0);
    clr(nb);
    s0 = sent;
    cfg.cont <= 1'h1;
    conv(16'h0003, 16'h0004, 1'h0);
    cfg.cont <= 1'h0;
    repeat (20) @(posedge clock_i);
    cmp("sample_count", sent - s0, {8'h00, cnt});
    cmp("accumulator", (sent - s0) * 16'h0003, acc);
    $display("test continuous done");
    test_done();
  end
endmodule
